// *** verilog/tmr_pkg.sv ***
//
// Behaviour
// R1: counter and both compare values are 8-bit
// R2: tick from prescaler or external pin edge
// R3: clock select zero stops the counter
// R4: each tick clears, increments or decrements counter
// R5: cpu counter access always; write beats counting
// R6: 3-bit waveform mode split over two controls
// R7: bottom 0x00, max 0xFF, top mode-dependent
// R8: equality sets match flag at next tick
// R9: flag cleared by service or writing one
// R10: three flags, each gated by mask bit
// R11: overflow flag set per mode, may interrupt
// R12: compare buffered in pwm, direct otherwise
// R13: buffer loads only at top or bottom
// R14: cpu compare access targets buffer when buffered
// R15: outputs from match, mode and output mode
// R16: mode zero counts up, overflow on wrap
// R17: mode two clears on compare a match
// R18: counter write blocks matches next tick
// R19: force strobe updates output in non-pwm modes
// R20: external pin synchronised, then edge detected
package tmr_pkg;

  // ************************************************
  // bus, data and prescaler widths
  // ************************************************
  localparam int DATA_W = 8;  // R1
  localparam int ADDR_W = 3;
  localparam int PRE_W  = 10;

  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [ADDR_W-1:0] ADR_CTRL_A  = 3'h0;
  localparam logic [ADDR_W-1:0] ADR_CTRL_B  = 3'h1;
  localparam logic [ADDR_W-1:0] ADR_COUNT   = 3'h2;
  localparam logic [ADDR_W-1:0] ADR_CMP_A   = 3'h3;
  localparam logic [ADDR_W-1:0] ADR_CMP_B   = 3'h4;
  localparam logic [ADDR_W-1:0] ADR_MASK    = 3'h5;
  localparam logic [ADDR_W-1:0] ADR_FLAGS   = 3'h6;

  // ************************************************
  // field positions
  // ************************************************
  localparam int CA_COM_A_LSB = 6;  // timer_ctrl_a [7:6]
  localparam int CA_COM_B_LSB = 4;  // timer_ctrl_a [5:4]
  localparam int CA_WGM_LSB   = 0;  // timer_ctrl_a [1:0]
  localparam int CB_FORCE_A   = 7;
  localparam int CB_FORCE_B   = 6;
  localparam int CB_WGM2      = 3;
  localparam int CB_CS_LSB    = 0;  // timer_ctrl_b [2:0]
  localparam int FL_MATCH_B   = 2;
  localparam int FL_MATCH_A   = 1;
  localparam int FL_OVERFLOW  = 0;

  // ************************************************
  // reset values and extreme counts
  // ************************************************
  localparam logic [DATA_W-1:0] RST_BYTE   = 8'h00;
  localparam logic [DATA_W-1:0] CNT_BOTTOM = 8'h00;  // R7
  localparam logic [DATA_W-1:0] CNT_MAX    = 8'hFF;  // R7

  // ************************************************
  // clock select codes and prescaler masks
  // ************************************************
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_D64  = 3'h3;
  localparam logic [2:0] CS_D256 = 3'h4;
  localparam logic [2:0] CS_D1K  = 3'h5;
  localparam logic [2:0] CS_FALL = 3'h6;
  localparam logic [2:0] CS_RISE = 3'h7;
  localparam logic [PRE_W-1:0] PRE_MASK_8   = 10'h007;
  localparam logic [PRE_W-1:0] PRE_MASK_64  = 10'h03F;
  localparam logic [PRE_W-1:0] PRE_MASK_256 = 10'h0FF;
  localparam logic [PRE_W-1:0] PRE_MASK_1K  = 10'h3FF;

  // ************************************************
  // output mode codes
  // ************************************************
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

endpackage : tmr_pkg

// *** verilog/tmr_tick_if.sv ***
// ************************************************
// clock select down, timer tick up
// ************************************************
interface tmr_tick_if;
  logic [2:0] clock_select_field;
  logic       timer_tick;
  modport src (input clock_select_field, output timer_tick);
  modport user (output clock_select_field, input timer_tick);
endinterface : tmr_tick_if

// *** verilog/tmr_tick_gen.sv ***
module tmr_tick_gen
  import tmr_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst,
  input wire logic   ext_count_pin,
  tmr_tick_if.src    tif
);

  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic             sync3;
    logic [PRE_W-1:0] pre;
    logic             tick;
  } tmr_tick_st_t;

  tmr_tick_st_t s_ff;
  tmr_tick_st_t nxt_s;

  // prescaler tap: all masked bits at zero
  function automatic logic pre_hit(input logic [PRE_W-1:0] pre,
                                   input logic [PRE_W-1:0] mask);
    pre_hit = (pre & mask) == '0;
  endfunction : pre_hit

  // ************************************************
  // source and edge select
  // ************************************************
  always_comb begin
    nxt_s       = s_ff;
    nxt_s.sync1 = ext_count_pin;          // R20
    nxt_s.sync2 = s_ff.sync1;             // R20
    nxt_s.sync3 = s_ff.sync2;
    nxt_s.pre   = s_ff.pre + 1'b1;
    unique case (tif.clock_select_field)  // R2
      CS_STOP: nxt_s.tick = 1'b0;         // R3
      CS_DIV1: nxt_s.tick = 1'b1;
      CS_DIV8: nxt_s.tick = pre_hit(s_ff.pre, PRE_MASK_8);
      CS_D64:  nxt_s.tick = pre_hit(s_ff.pre, PRE_MASK_64);
      CS_D256: nxt_s.tick = pre_hit(s_ff.pre, PRE_MASK_256);
      CS_D1K:  nxt_s.tick = pre_hit(s_ff.pre, PRE_MASK_1K);
      CS_FALL: nxt_s.tick = s_ff.sync3 & ~s_ff.sync2;  // R20
      CS_RISE: nxt_s.tick = s_ff.sync2 & ~s_ff.sync3;  // R20
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tif.timer_tick = s_ff.tick;

endmodule : tmr_tick_gen

// *** verilog/tmr_wave_out.sv ***
module tmr_wave_out
  import tmr_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       match_evt,
  input wire logic       force_evt,
  input wire logic       bottom_evt,
  input wire logic       mode_fast,
  input wire logic       mode_phase,
  input wire logic       count_up,
  input wire logic       toggle_ok,
  input wire logic [1:0] com,
  output logic           oc
);

  typedef struct packed {
    logic oc;
  } tmr_wave_st_t;

  tmr_wave_st_t s_ff;
  tmr_wave_st_t nxt_s;

  // ************************************************
  // waveform action per mode
  // ************************************************
  always_comb begin
    nxt_s = s_ff;
    if (mode_fast) begin
      if (match_evt) begin  // R15
        unique case (com)
          COM_TOGGLE: nxt_s.oc = toggle_ok ? ~s_ff.oc : s_ff.oc;
          COM_CLEAR:  nxt_s.oc = 1'b0;
          COM_SET:    nxt_s.oc = 1'b1;
          COM_OFF:    nxt_s.oc = s_ff.oc;
        endcase
      end else if (bottom_evt) begin  // R15
        if (com == COM_CLEAR) begin
          nxt_s.oc = 1'b1;
        end else if (com == COM_SET) begin
          nxt_s.oc = 1'b0;
        end
      end
    end else if (mode_phase) begin
      if (match_evt) begin  // R15
        unique case (com)
          COM_TOGGLE: nxt_s.oc = toggle_ok ? ~s_ff.oc : s_ff.oc;
          COM_CLEAR:  nxt_s.oc = ~count_up;
          COM_SET:    nxt_s.oc = count_up;
          COM_OFF:    nxt_s.oc = s_ff.oc;
        endcase
      end
    end else if (match_evt || force_evt) begin  // R19
      unique case (com)
        COM_TOGGLE: nxt_s.oc = ~s_ff.oc;
        COM_CLEAR:  nxt_s.oc = 1'b0;
        COM_SET:    nxt_s.oc = 1'b1;
        COM_OFF:    nxt_s.oc = s_ff.oc;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign oc = s_ff.oc;

endmodule : tmr_wave_out

// *** verilog/tmr_top.sv ***
module tmr_top
  import tmr_pkg::*;
(
  input wire logic                       SYS_CLK,
  input wire logic                       RST,
  input wire logic [tmr_pkg::ADDR_W-1:0] ADDR,
  input wire logic [tmr_pkg::DATA_W-1:0] WR_DATA,
  input wire logic                       WR_EN,
  input wire logic                       RD_EN,
  output logic     [tmr_pkg::DATA_W-1:0] RD_DATA,
  input wire logic                       EXT_COUNT_PIN,
  input wire logic [2:0]                 INT_ACK,
  output logic                           IRQ_OVERFLOW,
  output logic                           IRQ_MATCH_A,
  output logic                           IRQ_MATCH_B,
  output logic                           COMPARE_OUT_A,
  output logic                           COMPARE_OUT_B
);

  typedef struct packed {
    logic [DATA_W-1:0] count_value;
    logic [DATA_W-1:0] compare_value_a;
    logic [DATA_W-1:0] compare_value_b;
    logic [DATA_W-1:0] buffer_a;
    logic [DATA_W-1:0] buffer_b;
    logic [1:0]        com_a;
    logic [1:0]        com_b;
    logic [2:0]        wgm;
    logic [2:0]        cs;
    logic [2:0]        mask;
    logic [2:0]        flags;
    logic              count_down;
    logic              block;
    logic [DATA_W-1:0] rdata;
    logic [2:0]        irq;
  } tmr_state_t;

  tmr_state_t s_ff;
  tmr_state_t nxt_s;

  tmr_tick_if tick_bus ();

  logic              tick;
  logic              mode_pwm;
  logic              mode_fast;
  logic              mode_phase;
  logic              mode_ctc;
  logic [DATA_W-1:0] top_value;
  logic              hit_a;
  logic              hit_b;
  logic              match_evt_a;
  logic              match_evt_b;
  logic              bottom_evt;
  logic              force_a;
  logic              force_b;
  logic              wr_ctrl_b;

  // ************************************************
  // mode decode
  // ************************************************
  assign tick       = tick_bus.timer_tick;
  assign mode_pwm   = s_ff.wgm[0];                    // R12
  assign mode_phase = s_ff.wgm[1:0] == 2'h1;
  assign mode_fast  = s_ff.wgm[1:0] == 2'h3;
  assign mode_ctc   = s_ff.wgm[1:0] == 2'h2;          // R17
  assign top_value  = s_ff.wgm[2] ? s_ff.compare_value_a : CNT_MAX;  // R7
  assign tick_bus.clock_select_field = s_ff.cs;

  // ************************************************
  // comparators and output events
  // ************************************************
  assign hit_a       = s_ff.count_value == s_ff.compare_value_a;  // R8
  assign hit_b       = s_ff.count_value == s_ff.compare_value_b;  // R8
  assign match_evt_a = tick & hit_a & ~s_ff.block;                // R18
  assign match_evt_b = tick & hit_b & ~s_ff.block;                // R18
  assign bottom_evt  = tick & mode_fast & (s_ff.count_value == top_value);
  assign wr_ctrl_b   = WR_EN & (ADDR == ADR_CTRL_B);
  assign force_a     = wr_ctrl_b & WR_DATA[CB_FORCE_A] & ~mode_pwm;  // R19
  assign force_b     = wr_ctrl_b & WR_DATA[CB_FORCE_B] & ~mode_pwm;  // R19

  // ************************************************
  // counter, buffers, flags and register port
  // ************************************************
  always_comb begin
    logic [2:0] set_fl;
    logic [2:0] clr_fl;
    logic       load_buf;
    set_fl   = 3'h0;
    clr_fl   = INT_ACK;                                   // R9
    load_buf = 1'b0;
    nxt_s    = s_ff;
    // counting sequence
    if (tick) begin
      nxt_s.block = 1'b0;                                 // R18
      set_fl[FL_MATCH_A] = match_evt_a;                   // R8
      set_fl[FL_MATCH_B] = match_evt_b;                   // R8
      if (mode_fast) begin
        if (s_ff.count_value == top_value) begin
          nxt_s.count_value   = CNT_BOTTOM;               // R4
          set_fl[FL_OVERFLOW] = 1'b1;                     // R11
          load_buf            = 1'b1;                     // R13
        end else begin
          nxt_s.count_value = s_ff.count_value + 8'h01;   // R4
        end
      end else if (mode_phase) begin
        if (!s_ff.count_down) begin
          if (s_ff.count_value == top_value) begin
            nxt_s.count_down  = 1'b1;
            nxt_s.count_value = s_ff.count_value - 8'h01; // R4
            load_buf          = 1'b1;                     // R13
          end else begin
            nxt_s.count_value = s_ff.count_value + 8'h01;
          end
        end else if (s_ff.count_value == CNT_BOTTOM) begin
          nxt_s.count_down    = 1'b0;
          nxt_s.count_value   = s_ff.count_value + 8'h01;
          set_fl[FL_OVERFLOW] = 1'b1;                     // R11
        end else begin
          nxt_s.count_value = s_ff.count_value - 8'h01;
        end
      end else begin
        nxt_s.count_down = 1'b0;
        if (mode_ctc && match_evt_a) begin
          nxt_s.count_value = CNT_BOTTOM;                 // R17
        end else begin
          nxt_s.count_value = s_ff.count_value + 8'h01;   // R16
        end
        if (s_ff.count_value == CNT_MAX) begin
          set_fl[FL_OVERFLOW] = 1'b1;                     // R16
        end
      end
    end
    if (load_buf) begin
      nxt_s.compare_value_a = s_ff.buffer_a;              // R13
      nxt_s.compare_value_b = s_ff.buffer_b;              // R13
    end
    // register writes
    if (WR_EN) begin
      unique case (ADDR)
        ADR_CTRL_A: begin
          nxt_s.com_a    = WR_DATA[CA_COM_A_LSB +: 2];
          nxt_s.com_b    = WR_DATA[CA_COM_B_LSB +: 2];
          nxt_s.wgm[1:0] = WR_DATA[CA_WGM_LSB +: 2];      // R6
        end
        ADR_CTRL_B: begin
          nxt_s.wgm[2] = WR_DATA[CB_WGM2];                // R6
          nxt_s.cs     = WR_DATA[CB_CS_LSB +: 3];
        end
        ADR_COUNT: begin
          nxt_s.count_value = WR_DATA;                    // R5
          nxt_s.block       = 1'b1;                       // R18
        end
        ADR_CMP_A: begin
          nxt_s.buffer_a = WR_DATA;                       // R14
          if (!mode_pwm) begin
            nxt_s.compare_value_a = WR_DATA;              // R14
          end
        end
        ADR_CMP_B: begin
          nxt_s.buffer_b = WR_DATA;                       // R14
          if (!mode_pwm) begin
            nxt_s.compare_value_b = WR_DATA;              // R14
          end
        end
        ADR_MASK:  nxt_s.mask = WR_DATA[2:0];             // R10
        ADR_FLAGS: clr_fl = clr_fl | WR_DATA[2:0];        // R9
        default: ;
      endcase
    end
    // flags: set wins over clear
    nxt_s.flags = (s_ff.flags & ~clr_fl) | set_fl;        // R9
    nxt_s.irq   = nxt_s.flags & nxt_s.mask;               // R10
    // read data, valid the cycle after the strobe
    nxt_s.rdata = RST_BYTE;
    if (RD_EN) begin
      unique case (ADDR)
        ADR_CTRL_A: nxt_s.rdata = {s_ff.com_a, s_ff.com_b, 2'h0, s_ff.wgm[1:0]};
        ADR_CTRL_B: nxt_s.rdata = {4'h0, s_ff.wgm[2], s_ff.cs};
        ADR_COUNT:  nxt_s.rdata = s_ff.count_value;       // R5
        ADR_CMP_A:  nxt_s.rdata = mode_pwm ? s_ff.buffer_a : s_ff.compare_value_a;  // R14
        ADR_CMP_B:  nxt_s.rdata = mode_pwm ? s_ff.buffer_b : s_ff.compare_value_b;  // R14
        ADR_MASK:   nxt_s.rdata = {5'h00, s_ff.mask};
        ADR_FLAGS:  nxt_s.rdata = {5'h00, s_ff.flags};    // R10
        default:    nxt_s.rdata = RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ************************************************
  // tick source and waveform channels
  // ************************************************
  tmr_tick_gen u_tick (
    .clk           (SYS_CLK),
    .rst           (RST),
    .ext_count_pin (EXT_COUNT_PIN),
    .tif           (tick_bus)
  );

  tmr_wave_out u_wave_a (
    .clk        (SYS_CLK),
    .rst        (RST),
    .match_evt  (match_evt_a),
    .force_evt  (force_a),
    .bottom_evt (bottom_evt),
    .mode_fast  (mode_fast),
    .mode_phase (mode_phase),
    .count_up   (~s_ff.count_down),
    .toggle_ok  (s_ff.wgm[2]),
    .com        (s_ff.com_a),
    .oc         (COMPARE_OUT_A)
  );

  tmr_wave_out u_wave_b (
    .clk        (SYS_CLK),
    .rst        (RST),
    .match_evt  (match_evt_b),
    .force_evt  (force_b),
    .bottom_evt (bottom_evt),
    .mode_fast  (mode_fast),
    .mode_phase (mode_phase),
    .count_up   (~s_ff.count_down),
    .toggle_ok  (1'b0),
    .com        (s_ff.com_b),
    .oc         (COMPARE_OUT_B)
  );

  assign RD_DATA      = s_ff.rdata;
  assign IRQ_OVERFLOW = s_ff.irq[FL_OVERFLOW];
  assign IRQ_MATCH_A  = s_ff.irq[FL_MATCH_A];
  assign IRQ_MATCH_B  = s_ff.irq[FL_MATCH_B];

endmodule : tmr_top

// *** test/tmr_properties.sv ***
module tmr_properties
  import tmr_pkg::*;
(
  input wire logic                       SYS_CLK,
  input wire logic                       RST,
  input wire logic [tmr_pkg::ADDR_W-1:0] ADDR,
  input wire logic [tmr_pkg::DATA_W-1:0] WR_DATA,
  input wire logic                       WR_EN,
  input wire logic                       RD_EN,
  input wire logic [tmr_pkg::DATA_W-1:0] RD_DATA,
  input wire logic [2:0]                 INT_ACK,
  input wire logic                       IRQ_OVERFLOW,
  input wire logic                       IRQ_MATCH_A,
  input wire logic                       IRQ_MATCH_B,
  input wire logic                       COMPARE_OUT_A,
  input wire logic                       COMPARE_OUT_B
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [2:0] mask_ff;
  logic [2:0] cs_ff;
  logic [1:0] idle_ff;
  logic       stopped;

  // ************************************************
  // shadow of mask and clock select, stop detection
  // ************************************************
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      mask_ff <= 3'h0;
      cs_ff   <= 3'h0;
      idle_ff <= 2'h3;
    end else begin
      if (WR_EN && ADDR == ADR_MASK) mask_ff <= WR_DATA[2:0];
      if (WR_EN && ADDR == ADR_CTRL_B) cs_ff <= WR_DATA[2:0];
      idle_ff <= (cs_ff != 3'h0) ? 2'h0 : ((idle_ff == 2'h3) ? idle_ff : idle_ff + 2'h1);
    end
  end
  // stopped long enough for the tick pipeline to be empty
  assign stopped = (cs_ff == 3'h0) && (idle_ff == 2'h3);

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  // ************************************************
  // counter write followed by counter read
  // ************************************************
  sequence seq_cnt_wr;
    stopped && WR_EN && ADDR == ADR_COUNT;
  endsequence
  sequence seq_cnt_rd;
    RD_EN && ADDR == ADR_COUNT;
  endsequence

  chk_rd_idle_zero: assert property (!RD_EN |=> RD_DATA == 8'h00)
    else $error("read data not zero outside read answer");
  chk_unmapped_read: assert property (RD_EN && ADDR == 3'h7 |=> RD_DATA == 8'h00)
    else $error("unmapped read not zero");
  chk_flag_upper_zero: assert property (RD_EN && ADDR == ADR_FLAGS |=> RD_DATA[7:3] == 5'h00)
    else $error("flag register upper bits not zero");
  chk_force_reads_zero: assert property (RD_EN && ADDR == ADR_CTRL_B |=> RD_DATA[7:6] == 2'h0)
    else $error("force strobes read back nonzero");
  chk_mask_readback: assert property (RD_EN && ADDR == ADR_MASK |=> RD_DATA == {5'h00, $past(mask_ff)})
    else $error("mask readback wrong");
  chk_irq_masked: assert property ((~mask_ff & {IRQ_MATCH_B, IRQ_MATCH_A, IRQ_OVERFLOW}) == 3'h0)
    else $error("interrupt request raised while masked");
  chk_ack_clears: assert property (stopped && INT_ACK[1] |=> !IRQ_MATCH_A)
    else $error("service acknowledge did not clear match a");
  chk_wr1_clears: assert property (stopped && WR_EN && ADDR == ADR_FLAGS && WR_DATA[2] |=> !IRQ_MATCH_B)
    else $error("write one did not clear match b");
  chk_count_readback: assert property (seq_cnt_wr ##1 !(WR_EN && ADDR == ADR_COUNT)
    ##1 seq_cnt_rd |=> RD_DATA == $past(WR_DATA, 3))
    else $error("stopped counter lost written value");
  chk_reset_quiet: assert property ($fell(RST) |-> !(IRQ_OVERFLOW | IRQ_MATCH_A | IRQ_MATCH_B | COMPARE_OUT_A | COMPARE_OUT_B))
    else $error("output high after reset release");

endmodule : tmr_properties

bind tmr_top tmr_properties tmr_properties_inst (.SYS_CLK, .RST, .ADDR, .WR_DATA, .WR_EN,
  .RD_EN, .RD_DATA, .INT_ACK, .IRQ_OVERFLOW, .IRQ_MATCH_A, .IRQ_MATCH_B, .COMPARE_OUT_A,
  .COMPARE_OUT_B);

// *** test/tmr_top_tb_top.sv ***
module tmr_top_tb_top
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              SYS_CLK;
  logic              RST;
  logic [ADDR_W-1:0] ADDR;
  logic [DATA_W-1:0] WR_DATA;
  logic              WR_EN;
  logic              RD_EN;
  logic [DATA_W-1:0] RD_DATA;
  logic              EXT_COUNT_PIN;
  logic [2:0]        INT_ACK;
  logic              IRQ_OVERFLOW;
  logic              IRQ_MATCH_A;
  logic              IRQ_MATCH_B;
  logic              COMPARE_OUT_A;
  logic              COMPARE_OUT_B;
  int                n_mismatch;
  int                total_checks;
  // force table: control a, control b, expected {out_b, out_a}
  logic [7:0]        frc_a [4] = '{8'h40, 8'h40, 8'h30, 8'h20};
  logic [7:0]        frc_b [4] = '{8'h80, 8'h80, 8'h40, 8'h40};
  logic [1:0]        frc_o [4] = '{2'h1, 2'h0, 2'h2, 2'h0};

  tmr_top tmr_top_inst (.SYS_CLK, .RST, .ADDR, .WR_DATA, .WR_EN, .RD_EN, .RD_DATA,
    .EXT_COUNT_PIN, .INT_ACK, .IRQ_OVERFLOW, .IRQ_MATCH_A, .IRQ_MATCH_B, .COMPARE_OUT_A,
    .COMPARE_OUT_B);

  // clock, 25 ns period
  always #12.5 SYS_CLK = ~SYS_CLK;

  // ************************************************
  // bus, pin and compare tasks
  // ************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge SYS_CLK);
    ADDR    <= a;
    WR_DATA <= d;
    WR_EN   <= 1'b1;
    @(posedge SYS_CLK);
    WR_EN   <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge SYS_CLK);
    ADDR  <= a;
    RD_EN <= 1'b1;
    @(posedge SYS_CLK);
    RD_EN <= 1'b0;
    #1;
    chk(RD_DATA, exp);
  endtask : rdc

  // full pulses on the count pin, each one edge of either kind
  task automatic pins(input int n);
    repeat (n) begin
      @(posedge SYS_CLK);
      EXT_COUNT_PIN <= 1'b1;
      repeat (6) @(posedge SYS_CLK);
      EXT_COUNT_PIN <= 1'b0;
      repeat (6) @(posedge SYS_CLK);
    end
  endtask : pins

  task automatic ack(input logic [2:0] b);
    @(posedge SYS_CLK);
    INT_ACK <= b;
    @(posedge SYS_CLK);
    INT_ACK <= 3'h0;
    repeat (2) @(posedge SYS_CLK);
  endtask : ack

  task automatic stop();
    wr(ADR_CTRL_B, 8'h00);
    repeat (4) @(posedge SYS_CLK);
  endtask : stop

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : test_done

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    SYS_CLK = 1'b0;
    RST = 1'b1;
    ADDR = '0;
    WR_DATA = '0;
    WR_EN = 1'b0;
    RD_EN = 1'b0;
    EXT_COUNT_PIN = 1'b0;
    INT_ACK = 3'h0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (20) @(posedge SYS_CLK);
    RST <= 1'b0;
    rdc(ADR_FLAGS, 8'h00);
    rdc(ADR_COUNT, 8'h00);
    wr(ADR_CMP_A, 8'hA5);
    rdc(ADR_CMP_A, 8'hA5);
    wr(ADR_CMP_B, 8'h5A);
    rdc(ADR_CMP_B, 8'h5A);
    wr(ADR_CTRL_B, 8'hC8);
    rdc(ADR_CTRL_B, 8'h08);
    wr(ADR_CTRL_B, 8'h00);
    wr(ADR_MASK, 8'h07);
    rdc(ADR_MASK, 8'h07);
    wr(3'h7, 8'hFF);
    rdc(3'h7, 8'h00);
    wr(ADR_COUNT, 8'hFE);
    rdc(ADR_COUNT, 8'hFE);
    repeat (10) @(posedge SYS_CLK);
    rdc(ADR_COUNT, 8'hFE);
    // normal mode on rising pin edges, wrap and overflow
    wr(ADR_CTRL_B, {5'h00, CS_RISE});
    pins(1);
    rdc(ADR_COUNT, 8'hFF);
    rdc(ADR_FLAGS, 8'h00);
    pins(1);
    rdc(ADR_COUNT, 8'h00);
    rdc(ADR_FLAGS, 8'h01);
    chk({7'h00, IRQ_OVERFLOW}, 8'h01);
    ack(3'h1);
    chk({7'h00, IRQ_OVERFLOW}, 8'h00);
    // clear on compare a, falling pin edges
    stop();
    wr(ADR_CMP_A, 8'h03);
    wr(ADR_COUNT, 8'h00);
    wr(ADR_CTRL_A, 8'h02);
    wr(ADR_CTRL_B, {5'h00, CS_FALL});
    pins(5);
    rdc(ADR_COUNT, 8'h01);
    rdc(ADR_FLAGS, 8'h02);
    chk({7'h00, IRQ_MATCH_A}, 8'h01);
    stop();
    ack(3'h2);
    rdc(ADR_FLAGS, 8'h00);
    // counter write blocks the next match
    wr(ADR_CTRL_A, 8'h00);
    wr(ADR_CMP_B, 8'h0A);
    wr(ADR_COUNT, 8'h0A);
    wr(ADR_CTRL_B, {5'h00, CS_RISE});
    pins(1);
    rdc(ADR_FLAGS, 8'h00);
    rdc(ADR_COUNT, 8'h0B);
    wr(ADR_COUNT, 8'h09);
    pins(2);
    rdc(ADR_FLAGS, 8'h04);
    chk({7'h00, IRQ_MATCH_B}, 8'h01);
    stop();
    wr(ADR_FLAGS, 8'h04);
    rdc(ADR_FLAGS, 8'h00);
    // forced compare: toggle, set and clear
    for (int i = 0; i < 4; i++) begin
      wr(ADR_CTRL_A, frc_a[i]);
      wr(ADR_CTRL_B, frc_b[i]);
      repeat (3) @(posedge SYS_CLK);
      chk({6'h00, COMPARE_OUT_B, COMPARE_OUT_A}, {6'h00, frc_o[i]});
    end
    rdc(ADR_FLAGS, 8'h00);
    // undivided tick: two ticks for a select held two cycles
    wr(ADR_COUNT, 8'h10);
    wr(ADR_CTRL_B, {5'h00, CS_DIV1});
    wr(ADR_CTRL_B, 8'h00);
    rdc(ADR_COUNT, 8'h12);
    // fast pwm: compare b buffered until top to bottom
    wr(ADR_CTRL_A, 8'h03);
    wr(ADR_CMP_B, 8'h02);
    rdc(ADR_CMP_B, 8'h02);
    wr(ADR_COUNT, 8'h00);
    wr(ADR_CTRL_B, {5'h00, CS_RISE});
    pins(4);
    rdc(ADR_FLAGS, 8'h02);
    wr(ADR_FLAGS, 8'h07);
    wr(ADR_COUNT, 8'hFE);
    pins(2);
    rdc(ADR_FLAGS, 8'h01);
    wr(ADR_FLAGS, 8'h07);
    pins(3);
    rdc(ADR_FLAGS, 8'h04);
    // phase correct: turns down at top
    stop();
    wr(ADR_FLAGS, 8'h07);
    wr(ADR_CTRL_A, 8'h01);
    wr(ADR_COUNT, 8'hFE);
    wr(ADR_CTRL_B, {5'h00, CS_RISE});
    pins(3);
    rdc(ADR_COUNT, 8'hFD);
    // fast pwm with compare a as top
    stop();
    wr(ADR_CTRL_A, 8'h03);
    wr(ADR_COUNT, 8'h02);
    wr(ADR_CTRL_B, 8'h0F);
    pins(2);
    rdc(ADR_COUNT, 8'h00);
    rdc(ADR_FLAGS, 8'h03);
    test_done();
  end

  // watchdog against a hung sequence
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    n_mismatch++;
    test_done();
  end

endmodule : tmr_top_tb_top
